// ### core/msd_decoder.sv
// Memory space decoder for program, data-read and data-write buses
`timescale 1ns/1ps
module msd_decoder
	import msd_pkg::*;
(
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             boot_source_pin_i,
	input  wire logic             shared_ram_enable_pin_i,
	input  wire msd_req_s         program_address_bus_i,
	input  wire msd_req_s         data_read_address_bus_i,
	input  wire msd_req_s         data_write_address_bus_i,
	input  wire logic             direct_mode_i,
	input  wire logic [OFS_W-1:0] direct_offset_i,
	input  wire logic [15:0]      data_write_bus_i,
	input  wire logic             remap_set_i,
	input  wire logic             remap_clear_i,
	input  wire logic [DP_W-1:0]  data_page_pointer_i,
	input  wire logic             io_space_i,
	output msd_sel_s              prog_sel_o,
	output msd_sel_s              rd_sel_o,
	output msd_sel_s              wr_sel_o,
	output logic                  ext_prog_strobe_n_o,
	output logic                  data_space_strobe_n_o,
	output logic                  global_access_strobe_n_o,
	output logic                  io_space_strobe_n_o,
	output logic [15:0]           reg_read_data_o,
	output logic [15:0]           scratch_read_data_o,
	output logic                  ram_block_remap_bit_o,
	output logic [15:0]           interrupt_mask_o,
	output logic [15:0]           global_window_allocation_o,
	output logic [15:0]           interrupt_flags_o,
	output logic                  first_fetch_o
);
	logic       boot_level;
	logic       shared_level;
	logic       ram_block_remap_bit;
	logic [15:0] interrupt_mask;
	logic [15:0] global_window_allocation;
	logic [15:0] interrupt_flags;
	msd_state_e state;
	msd_state_e next_state;

	// Pins are static straps but still pass a synchroniser before decode
	msd_pin_sync u_boot_sync (
		.clock_i (clock_i),
		.pin_i   (boot_source_pin_i),
		.level_o (boot_level)
	);
	msd_pin_sync u_shared_sync (
		.clock_i (clock_i),
		.pin_i   (shared_ram_enable_pin_i),
		.level_o (shared_level)
	);

	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// Global window: leading ones of the low byte match the top address bits
	function automatic logic global_hit(input logic [15:0] a, input logic [7:0] alloc);
		global_hit = (alloc != 8'h00) && ((a[15:8] & alloc) == alloc); // [R21]
	endfunction

	// One data target per address; on-chip ranges win over external
	function automatic msd_target_e data_target(input logic [15:0] a, input logic remap, input logic shared);
		if (a <= PAGE0_HI) begin // [R15]
			if (in_rng(a, SCR_LO, PAGE0_HI))
				data_target = MSD_T_SCR; // [R19]
			else if (in_rng(a, TEST_LO, TEST_HI))
				data_target = MSD_T_TEST;
			else if (a == ADR_MASK || a == ADR_ALLOC || a == ADR_FLAGS)
				data_target = MSD_T_REG; // [R16]
			else
				data_target = MSD_T_RSV; // [R18]
		end else if (in_rng(a, B0_BASE, B1_BASE - 16'h0001))
			data_target = remap ? MSD_T_EXT : MSD_T_B0; // [R5] [R13]
		else if (in_rng(a, B1_BASE, B1_END))
			data_target = MSD_T_B1; // [R13]
		else if (in_rng(a, SH_LO, SH_HI))
			data_target = shared ? MSD_T_SHARED : MSD_T_EXT; // [R10] [R11]
		else
			data_target = MSD_T_EXT; // [R22]
	endfunction

	function automatic msd_target_e prog_target(input logic [15:0] a, input logic remap, input logic shared,
		input logic boot);
		if (remap && a >= PRG_B0_BASE)
			prog_target = MSD_T_B0; // [R5]
		else if (in_rng(a, SH_LO, SH_HI))
			prog_target = shared ? MSD_T_SHARED : MSD_T_EXT; // [R10] [R11]
		else if (!boot && a <= ROM_END)
			prog_target = MSD_T_ROM; // [R7]
		else
			prog_target = MSD_T_EXT; // [R4] [R8]
	endfunction

	// Direct addressing forms the data address from page pointer and offset
	wire [15:0] direct_addr = {data_page_pointer_i, direct_offset_i}; // [R14]
	wire [15:0] rd_addr     = direct_mode_i ? direct_addr : data_read_address_bus_i.addr;
	wire [15:0] wr_addr     = direct_mode_i ? direct_addr : data_write_address_bus_i.addr;
	// Until the vector fetch is done the program bus is forced to zero
	wire [15:0] pr_addr     = (state == MSD_ST_RUN) ? program_address_bus_i.addr : VEC_RESET; // [R9]

	wire msd_target_e pr_t = prog_target(pr_addr, ram_block_remap_bit, shared_level, boot_level);
	wire msd_target_e rd_t = data_target(rd_addr, ram_block_remap_bit, shared_level);
	wire msd_target_e wr_t = data_target(wr_addr, ram_block_remap_bit, shared_level);
	wire pr_v = program_address_bus_i.valid || state == MSD_ST_VECTOR;
	wire rd_v = data_read_address_bus_i.valid;
	wire wr_v = data_write_address_bus_i.valid;
	wire rd_glb = global_hit(rd_addr, global_window_allocation[7:0]);
	wire wr_glb = global_hit(wr_addr, global_window_allocation[7:0]);

	// Writes to reserved and test locations store nothing
	wire wr_reg  = wr_v && !io_space_i && wr_t == MSD_T_REG; // [R23] [R3]
	wire wr_scr  = wr_v && !io_space_i && wr_t == MSD_T_SCR;
	wire [15:0] next_reg_read =
		(rd_addr == ADR_MASK)  ? interrupt_mask :
		(rd_addr == ADR_ALLOC) ? global_window_allocation :
		(rd_addr == ADR_FLAGS) ? interrupt_flags : RSV_READ_VALUE; // [R23]

	// Reset walks through one vector fetch, then hands the bus to the core
	always_comb begin
		case (state)
			MSD_ST_RESET:  next_state = MSD_ST_VECTOR;
			MSD_ST_VECTOR: next_state = MSD_ST_RUN;
			MSD_ST_RUN:    next_state = MSD_ST_RUN;
			default:       next_state = MSD_ST_RESET;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= MSD_ST_RESET;
			ram_block_remap_bit <= REMAP_RESET; // [R6]
		end else begin
			state <= next_state;
			if (remap_set_i)
				ram_block_remap_bit <= 1'b1; // [R5]
			else if (remap_clear_i)
				ram_block_remap_bit <= 1'b0;
		end
	end

	// Registers respond in the same cycle, so they never add wait states
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			interrupt_mask           <= MASK_RESET;
			global_window_allocation <= ALLOC_RESET;
			interrupt_flags          <= FLAGS_RESET;
		end else if (wr_reg) begin // [R16]
			if (wr_addr == ADR_MASK)
				interrupt_mask <= data_write_bus_i;
			if (wr_addr == ADR_ALLOC)
				global_window_allocation <= {8'h00, data_write_bus_i[7:0]}; // [R21]
			if (wr_addr == ADR_FLAGS)
				interrupt_flags <= data_write_bus_i;
		end
	end

	msd_scratch_ram u_scratch (
		.clock_i (clock_i),
		.we_i    (wr_scr),
		.waddr_i (wr_addr[SCR_AW-1:0]),
		.wdata_i (data_write_bus_i),
		.raddr_i (rd_addr[SCR_AW-1:0]),
		.rdata_o (scratch_read_data_o)
	);

	// All three buses are decoded and registered side by side every cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			prog_sel_o               <= '{MSD_T_NONE, 1'b0, 1'b0, 16'h0000};
			rd_sel_o                 <= '{MSD_T_NONE, 1'b0, 1'b0, 16'h0000};
			wr_sel_o                 <= '{MSD_T_NONE, 1'b0, 1'b0, 16'h0000};
			ext_prog_strobe_n_o      <= 1'b1;
			data_space_strobe_n_o    <= 1'b1;
			global_access_strobe_n_o <= 1'b1;
			io_space_strobe_n_o      <= 1'b1;
			reg_read_data_o          <= RSV_READ_VALUE;
			first_fetch_o            <= 1'b0;
		end else begin
			prog_sel_o <= '{pr_v ? pr_t : MSD_T_NONE, pr_v && pr_t == MSD_T_EXT, 1'b0, pr_addr}; // [R1] [R2]
			rd_sel_o   <= '{(rd_v && !io_space_i) ? rd_t : MSD_T_NONE,
				rd_v && !io_space_i && rd_t == MSD_T_EXT, rd_v && rd_glb, rd_addr}; // [R1] [R2]
			wr_sel_o   <= '{(wr_v && !io_space_i) ? wr_t : MSD_T_NONE,
				wr_v && !io_space_i && wr_t == MSD_T_EXT, wr_v && wr_glb, wr_addr}; // [R1] [R2]
			ext_prog_strobe_n_o      <= !(pr_v && pr_t == MSD_T_EXT); // [R4] [R8]
			data_space_strobe_n_o    <= !((rd_v || wr_v) && !io_space_i); // [R20]
			global_access_strobe_n_o <= !(!io_space_i && ((rd_v && rd_glb) || (wr_v && wr_glb))); // [R20] [R3]
			io_space_strobe_n_o      <= !((rd_v || wr_v) && io_space_i); // [R3]
			reg_read_data_o          <= next_reg_read;
			first_fetch_o            <= state == MSD_ST_VECTOR; // [R9]
		end
	end

	assign ram_block_remap_bit_o      = ram_block_remap_bit;
	assign interrupt_mask_o           = interrupt_mask;
	assign global_window_allocation_o = global_window_allocation;
	assign interrupt_flags_o          = interrupt_flags;

	property p_remap_reset;
		@(posedge clock_i) rst_i |=> !ram_block_remap_bit;
	endproperty
	a_remap_reset: assert property (p_remap_reset) else $error("remap bit not cleared by reset"); // [R6]

	property p_vector_zero;
		@(posedge clock_i) disable iff (rst_i) first_fetch_o |-> prog_sel_o.addr == VEC_RESET;
	endproperty
	a_vector_zero: assert property (p_vector_zero) else $error("first fetch not at zero"); // [R9]

	property p_boot_ext;
		@(posedge clock_i) disable iff (rst_i) (state == MSD_ST_VECTOR && boot_level) |=> !ext_prog_strobe_n_o;
	endproperty
	a_boot_ext: assert property (p_boot_ext) else $error("microprocessor vector fetch not external"); // [R8]

	property p_boot_int;
		@(posedge clock_i) disable iff (rst_i)
			(state == MSD_ST_VECTOR && !boot_level && !ram_block_remap_bit) |=> prog_sel_o.target == MSD_T_ROM;
	endproperty
	a_boot_int: assert property (p_boot_int) else $error("microcomputer vector fetch not on chip"); // [R7]

	property p_page0_scr;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && !io_space_i && in_rng(rd_addr, SCR_LO, PAGE0_HI)) |=> rd_sel_o.target == MSD_T_SCR;
	endproperty
	a_page0_scr: assert property (p_page0_scr) else $error("scratch window misdecoded"); // [R19]

	property p_ds;
		@(posedge clock_i) disable iff (rst_i) (rd_v && !io_space_i) |=> !data_space_strobe_n_o;
	endproperty
	a_ds: assert property (p_ds) else $error("data strobe missing"); // [R20]

	property p_shared;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && !io_space_i && in_rng(rd_addr, SH_LO, SH_HI)) |=>
			rd_sel_o.target == ($past(shared_level) ? MSD_T_SHARED : MSD_T_EXT);
	endproperty
	a_shared: assert property (p_shared) else $error("shared window misdecoded"); // [R10]

	property p_rsv_write;
		@(posedge clock_i) disable iff (rst_i)
			(wr_v && wr_t == MSD_T_RSV) |=> $stable(interrupt_mask) && $stable(interrupt_flags);
	endproperty
	a_rsv_write: assert property (p_rsv_write) else $error("reserved write had an effect"); // [R23]

	property p_prog_b0;
		@(posedge clock_i) disable iff (rst_i)
			(pr_v && ram_block_remap_bit && pr_addr >= PRG_B0_BASE) |=> prog_sel_o.target == MSD_T_B0;
	endproperty
	a_prog_b0: assert property (p_prog_b0) else $error("remapped block zero not in program"); // [R5]

	property p_data_b0;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && !io_space_i && in_rng(rd_addr, B0_BASE, B1_BASE - 16'h0001)) |=>
			rd_sel_o.target == ($past(ram_block_remap_bit) ? MSD_T_EXT : MSD_T_B0);
	endproperty
	a_data_b0: assert property (p_data_b0) else $error("block zero data window misdecoded"); // [R5] [R13]

	property p_data_b1;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && !io_space_i && in_rng(rd_addr, B1_BASE, B1_END)) |=> rd_sel_o.target == MSD_T_B1;
	endproperty
	a_data_b1: assert property (p_data_b1) else $error("block one misdecoded"); // [R13]

	property p_rom_mc;
		@(posedge clock_i) disable iff (rst_i)
			(pr_v && !boot_level && !ram_block_remap_bit && pr_addr <= ROM_END) |=> prog_sel_o.target == MSD_T_ROM;
	endproperty
	a_rom_mc: assert property (p_rom_mc) else $error("on-chip program memory not selected"); // [R7]

	property p_rom_mp;
		@(posedge clock_i) disable iff (rst_i) (pr_v && boot_level) |=> prog_sel_o.target != MSD_T_ROM;
	endproperty
	a_rom_mp: assert property (p_rom_mp) else $error("on-chip program memory used when booting external"); // [R8]

	property p_prog_ext;
		@(posedge clock_i) disable iff (rst_i) (pr_v && pr_t == MSD_T_EXT) |=> !ext_prog_strobe_n_o && prog_sel_o.ext;
	endproperty
	a_prog_ext: assert property (p_prog_ext) else $error("external program access not started"); // [R4]

	property p_shared_prog;
		@(posedge clock_i) disable iff (rst_i)
			(pr_v && in_rng(pr_addr, SH_LO, SH_HI)) |=>
			prog_sel_o.target == ($past(shared_level) ? MSD_T_SHARED : MSD_T_EXT);
	endproperty
	a_shared_prog: assert property (p_shared_prog) else $error("shared program window misdecoded"); // [R10] [R11]

	property p_global;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && !io_space_i && rd_glb) |=> !global_access_strobe_n_o && rd_sel_o.global_hit;
	endproperty
	a_global: assert property (p_global) else $error("global strobe missing"); // [R20]

	property p_io;
		@(posedge clock_i) disable iff (rst_i)
			((rd_v || wr_v) && io_space_i) |=> !io_space_strobe_n_o && data_space_strobe_n_o && global_access_strobe_n_o;
	endproperty
	a_io: assert property (p_io) else $error("I/O access strobes wrong"); // [R3]

	property p_io_regs;
		@(posedge clock_i) disable iff (rst_i)
			(wr_v && io_space_i) |=> $stable(interrupt_mask) && $stable(global_window_allocation) && $stable(interrupt_flags);
	endproperty
	a_io_regs: assert property (p_io_regs) else $error("I/O write changed a data register"); // [R3]

	property p_no_alloc;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && global_window_allocation[7:0] == 8'h00) |=> !rd_sel_o.global_hit;
	endproperty
	a_no_alloc: assert property (p_no_alloc) else $error("global hit with empty window"); // [R21]

	property p_alloc_high;
		@(posedge clock_i) disable iff (rst_i) global_window_allocation[15:8] == 8'h00;
	endproperty
	a_alloc_high: assert property (p_alloc_high) else $error("allocation high byte not zero"); // [R21]

	property p_mask_write;
		@(posedge clock_i) disable iff (rst_i)
			(wr_v && !io_space_i && wr_addr == ADR_MASK) |=> interrupt_mask == $past(data_write_bus_i);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [R16]

	property p_alloc_write;
		@(posedge clock_i) disable iff (rst_i) (wr_v && !io_space_i && wr_addr == ADR_ALLOC) |=>
			global_window_allocation == {8'h00, $past(data_write_bus_i[7:0])};
	endproperty
	a_alloc_write: assert property (p_alloc_write) else $error("allocation write lost"); // [R21]

	property p_reg_read;
		@(posedge clock_i) disable iff (rst_i) (rd_addr == ADR_FLAGS) |=> reg_read_data_o == $past(interrupt_flags);
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("flag read wrong"); // [R16]

	property p_rsv_read;
		@(posedge clock_i) disable iff (rst_i)
			(rd_t == MSD_T_RSV || rd_t == MSD_T_TEST) |=> reg_read_data_o == RSV_READ_VALUE;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved read not fixed"); // [R23]

	property p_page0_rsv;
		@(posedge clock_i) disable iff (rst_i)
			(rd_v && !io_space_i && (in_rng(rd_addr, RSV0_LO, RSV0_HI) || in_rng(rd_addr, RSV1_LO, RSV1_HI))) |=>
			rd_sel_o.target == MSD_T_RSV;
	endproperty
	a_page0_rsv: assert property (p_page0_rsv) else $error("reserved location misdecoded"); // [R18]

	property p_direct;
		@(posedge clock_i) disable iff (rst_i)
			direct_mode_i |=> rd_sel_o.addr == $past(direct_addr) && wr_sel_o.addr == $past(direct_addr);
	endproperty
	a_direct: assert property (p_direct) else $error("direct address wrong"); // [R14]

	property p_run_addr;
		@(posedge clock_i) disable iff (rst_i)
			(state == MSD_ST_RUN) |=> prog_sel_o.addr == $past(program_address_bus_i.addr);
	endproperty
	a_run_addr: assert property (p_run_addr) else $error("program address not passed"); // [R1] [R9]
endmodule

// ### core/msd_pkg.sv
// Package with constants and types for the memory space decoder
// Notes on behaviour
// R1: Three address buses decoded independently, same cycle.
// R2: Three concurrent operations per cycle, never serialized.
// R3: Program, local, global, I/O spaces selectable.
// R4: Program address off-chip starts external access.
// R5: Remap bit twelve puts block zero in program.
// R6: Reset clears remap bit; block zero data.
// R7: Boot pin low: on-chip ROM decodes, vector internal.
// R8: Boot pin high: reset vector fetched externally.
// R9: First fetch after reset at address zero.
// R10: Shared enable high: both spaces share RAM word.
// R11: Shared enable low: window external in both.
// R12: Software avoids data writes over shared code.
// R13: Block zero program or data; others data only.
// R14: Direct address is page pointer plus offset.
// R15: Data page zero selects memory-mapped registers.
// R16: Mask, allocation, flag registers zero wait states.
// R17: Software never writes test/emulation area.
// R18: Reserved page-zero locations hold no register.
// R19: 0060h-007Fh selects 32-word scratch RAM.
// R20: Data access strobes data; global range adds global.
// R21: Allocation low byte selects top global window.
// R22: Static pins; one target, on-chip first.
// R23: Reserved reads fixed value; writes ignored.
package msd_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 16;
	localparam int          SCR_DEPTH       = 32;
	localparam int          SCR_AW          = 5;
	localparam int          B0_WORDS        = 512;
	localparam int          B0_AW           = 9;
	localparam logic [15:0] VEC_RESET       = 16'h0000;
	localparam logic [15:0] ADR_MASK        = 16'h0004;
	localparam logic [15:0] ADR_ALLOC       = 16'h0005;
	localparam logic [15:0] ADR_FLAGS       = 16'h0006;
	localparam logic [15:0] RSV0_LO         = 16'h0000;
	localparam logic [15:0] RSV0_HI         = 16'h0003;
	localparam logic [15:0] RSV1_LO         = 16'h0023;
	localparam logic [15:0] RSV1_HI         = 16'h0027;
	localparam logic [15:0] TEST_LO         = 16'h002B;
	localparam logic [15:0] TEST_HI         = 16'h002F;
	localparam logic [15:0] SCR_LO          = 16'h0060;
	localparam logic [15:0] PAGE0_HI        = 16'h007F;
	localparam logic [15:0] B0_BASE         = 16'h0200;
	localparam logic [15:0] B1_BASE         = 16'h0300;
	localparam logic [15:0] B1_END          = 16'h04FF;
	localparam logic [15:0] ROM_END         = 16'h1FFF;
	localparam logic [15:0] SH_LO           = 16'h8000;
	localparam logic [15:0] SH_HI           = 16'h87FF;
	localparam logic [15:0] PRG_B0_BASE     = 16'hFE00;
	localparam logic [15:0] RSV_READ_VALUE  = 16'h0000;
	localparam logic [15:0] MASK_RESET      = 16'h0000;
	localparam logic [15:0] ALLOC_RESET     = 16'h0000;
	localparam logic [15:0] FLAGS_RESET     = 16'h0000;
	localparam logic        REMAP_RESET     = 1'b0;
	localparam int          REMAP_BIT       = 12;
	localparam int          DP_W            = 9;
	localparam int          OFS_W           = 7;

	typedef enum logic [1:0] {MSD_SP_PROG, MSD_SP_DATA, MSD_SP_GLOBAL, MSD_SP_IO} msd_space_e;
	typedef enum logic [3:0] {
		MSD_T_NONE, MSD_T_EXT, MSD_T_B0, MSD_T_B1, MSD_T_SCR, MSD_T_SHARED,
		MSD_T_ROM, MSD_T_REG, MSD_T_RSV, MSD_T_TEST
	} msd_target_e;
	typedef enum logic [1:0] {MSD_ST_RESET, MSD_ST_VECTOR, MSD_ST_RUN} msd_state_e;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [15:0] addr;
	} msd_req_s;

	typedef struct packed {
		msd_target_e target;
		logic        ext;
		logic        global_hit;
		logic [15:0] addr;
	} msd_sel_s;
endpackage

// ### core/msd_scratch_ram.sv
// Small dual-port memory for the 32-word scratch block
`timescale 1ns/1ps
module msd_scratch_ram
	import msd_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              we_i,
	input  wire logic [SCR_AW-1:0] waddr_i,
	input  wire logic [15:0]       wdata_i,
	input  wire logic [SCR_AW-1:0] raddr_i,
	output logic      [15:0]       rdata_o
);
	logic [15:0] mem [SCR_DEPTH];

	// Read and write ports are separate so both data buses use it in one cycle
	always_ff @(posedge clock_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i; // [R19]
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ### core/msd_pin_sync.sv
// Two-stage synchroniser for the static configuration pins
`timescale 1ns/1ps
module msd_pin_sync
	import msd_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic stage1;

	// No reset: the strap level must already be settled when reset releases
	always_ff @(posedge clock_i) begin
		stage1  <= pin_i;
		level_o <= stage1; // [R22]
	end
endmodule

// ### tb/msd_ext_mem.sv
// External program memory model counting fetches the decoder sends off-chip
`timescale 1ns/1ps
module msd_ext_mem
	import msd_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        ext_prog_strobe_n_i,
	input  wire msd_sel_s    prog_sel_i,
	output logic      [15:0] fetch_count_o
);
	// Strobe and select flag must agree, so a half-asserted access is not counted
	wire fetch_hit = !ext_prog_strobe_n_i && prog_sel_i.ext;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fetch_count_o <= 16'h0000;
		end else if (fetch_hit) begin
			fetch_count_o <= fetch_count_o + 16'h0001;
		end
	end
endmodule

// ### tb/memory_space_decoder_tb.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
module memory_space_decoder_tb;
	import msd_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic boot_source_pin_i = 1'b0;
	logic shared_ram_enable_pin_i = 1'b1;
	msd_req_s pb = '0;
	msd_req_s rb = '0;
	msd_req_s wb = '0;
	logic direct_mode_i = 1'b0;
	logic [OFS_W-1:0] direct_offset_i = '0;
	logic [15:0] data_write_bus_i = 16'h0000;
	logic remap_set_i = 1'b0;
	logic remap_clear_i = 1'b0;
	logic [DP_W-1:0] data_page_pointer_i = '0;
	logic io_space_i = 1'b0;
	msd_sel_s ps, rs, ws;
	logic ext_n, ds_n, gs_n, io_n, ff, remap;
	logic [15:0] rrd, srd, msk, alc, flg, fcnt, f0;
	int err_total = 0;
	int comparisons = 0;
	const msd_req_s NONE = '0;
	logic [15:0] ta [9] = '{16'h0001, 16'h0024, 16'h002B, 16'h0004, 16'h0061, 16'h0200, 16'h0300, 16'h04FF,
		16'h8000};
	msd_target_e tt [9] = '{MSD_T_RSV, MSD_T_RSV, MSD_T_TEST, MSD_T_REG, MSD_T_SCR, MSD_T_B0, MSD_T_B1,
		MSD_T_B1, MSD_T_SHARED};

	msd_decoder dut (.clock_i(clock_i), .rst_i(rst_i), .boot_source_pin_i(boot_source_pin_i),
		.shared_ram_enable_pin_i(shared_ram_enable_pin_i), .program_address_bus_i(pb),
		.data_read_address_bus_i(rb), .data_write_address_bus_i(wb), .direct_mode_i(direct_mode_i),
		.direct_offset_i(direct_offset_i), .data_write_bus_i(data_write_bus_i), .remap_set_i(remap_set_i),
		.remap_clear_i(remap_clear_i), .data_page_pointer_i(data_page_pointer_i), .io_space_i(io_space_i),
		.prog_sel_o(ps), .rd_sel_o(rs), .wr_sel_o(ws), .ext_prog_strobe_n_o(ext_n),
		.data_space_strobe_n_o(ds_n), .global_access_strobe_n_o(gs_n), .io_space_strobe_n_o(io_n),
		.reg_read_data_o(rrd), .scratch_read_data_o(srd), .ram_block_remap_bit_o(remap),
		.interrupt_mask_o(msk), .global_window_allocation_o(alc), .interrupt_flags_o(flg),
		.first_fetch_o(ff));
	msd_ext_mem ext (.clock_i(clock_i), .rst_i(rst_i), .ext_prog_strobe_n_i(ext_n), .prog_sel_i(ps),
		.fetch_count_o(fcnt));

	always #12.5 clock_i = ~clock_i;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic msd_req_s rq(input logic w, input logic [15:0] a);
		return {1'b1, w, a};
	endfunction
	// Requests launch at a falling edge; outputs are checked at the next one
	task automatic cyc(input msd_req_s p, input msd_req_s r, input msd_req_s w);
		pb = p;
		rb = r;
		wb = w;
		@(negedge clock_i);
	endtask
	task automatic rst(input logic boot, input logic shen);
		rst_i = 1'b1;
		boot_source_pin_i = boot;
		shared_ram_enable_pin_i = shen;
		pb = NONE;
		rb = NONE;
		wb = NONE;
		repeat (20) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clock_i);
		chk(16'(ff), 16'h0001);
		chk(ps.addr, VEC_RESET);
		chk(16'(ps.target), boot ? 16'(MSD_T_EXT) : 16'(MSD_T_ROM));
		chk(16'(ext_n), 16'(!boot));
		chk(16'(remap), 16'h0000);
		@(negedge clock_i);
		chk(16'(ff), 16'h0000);
	endtask
	task automatic conclude();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#(25ns * 4000);
		err_total++;
		conclude();
	end

	initial begin
		rst(1'b0, 1'b1);
		data_write_bus_i = 16'h1234;
		cyc(NONE, NONE, rq(1'b1, ADR_MASK));
		data_write_bus_i = 16'hABE0;
		cyc(NONE, NONE, rq(1'b1, ADR_ALLOC));
		data_write_bus_i = 16'h00F0;
		cyc(NONE, NONE, rq(1'b1, ADR_FLAGS));
		data_write_bus_i = 16'h5A5A;
		cyc(NONE, NONE, rq(1'b1, 16'h0001));
		cyc(NONE, NONE, rq(1'b1, 16'h0061));
		chk(msk, 16'h1234);
		chk(alc, 16'h00E0);
		chk(flg, 16'h00F0);
		cyc(NONE, rq(1'b0, ADR_MASK), NONE);
		chk(rrd, 16'h1234);
		cyc(NONE, rq(1'b0, ADR_ALLOC), NONE);
		chk(rrd, 16'h00E0);
		cyc(NONE, rq(1'b0, ADR_FLAGS), NONE);
		chk(rrd, 16'h00F0);
		cyc(NONE, rq(1'b0, 16'h0001), NONE);
		chk(rrd, RSV_READ_VALUE);
		cyc(NONE, rq(1'b0, 16'h0061), NONE);
		chk(srd, 16'h5A5A);
		// Test area is only ever read, never written
		for (int i = 0; i < 9; i++) begin
			cyc(NONE, rq(1'b0, ta[i]), NONE);
			chk(16'(rs.target), 16'(tt[i]));
			chk(16'(ds_n), 16'h0000);
		end
		cyc(NONE, rq(1'b0, 16'hE000), NONE);
		chk(16'(gs_n), 16'h0000);
		chk(16'(rs.global_hit), 16'h0001);
		cyc(NONE, rq(1'b0, 16'hDFFF), NONE);
		chk(16'(gs_n), 16'h0001);
		// Shared window: data side writes scratch, so no code is overlaid
		cyc(rq(1'b0, SH_LO), rq(1'b0, SH_HI), rq(1'b1, 16'h0062));
		chk(16'(ps.target), 16'(MSD_T_SHARED));
		chk(16'(rs.target), 16'(MSD_T_SHARED));
		chk(16'(ws.target), 16'(MSD_T_SCR));
		shared_ram_enable_pin_i = 1'b0;
		repeat (3) cyc(NONE, NONE, NONE);
		f0 = fcnt;
		cyc(rq(1'b0, SH_LO), rq(1'b0, SH_LO), NONE);
		chk(16'(ps.target), 16'(MSD_T_EXT));
		chk(16'(rs.target), 16'(MSD_T_EXT));
		chk(16'(ext_n), 16'h0000);
		cyc(rq(1'b0, PRG_B0_BASE), NONE, NONE);
		chk(fcnt, f0 + 16'h0001);
		chk(16'(ps.target), 16'(MSD_T_EXT));
		remap_set_i = 1'b1;
		cyc(NONE, NONE, NONE);
		remap_set_i = 1'b0;
		chk(16'(remap), 16'h0001);
		cyc(rq(1'b0, PRG_B0_BASE), rq(1'b0, B0_BASE), NONE);
		chk(16'(ps.target), 16'(MSD_T_B0));
		chk(16'(rs.target), 16'(MSD_T_EXT));
		remap_clear_i = 1'b1;
		cyc(NONE, NONE, NONE);
		remap_clear_i = 1'b0;
		chk(16'(remap), 16'h0000);
		direct_mode_i = 1'b1;
		data_page_pointer_i = 9'h004;
		cyc(NONE, rq(1'b0, 16'hFFFF), NONE);
		chk(rs.addr, B0_BASE);
		data_page_pointer_i = 9'h000;
		direct_offset_i = 7'h05;
		cyc(NONE, rq(1'b0, 16'hFFFF), NONE);
		chk(16'(rs.target), 16'(MSD_T_REG));
		direct_mode_i = 1'b0;
		io_space_i = 1'b1;
		cyc(NONE, rq(1'b0, 16'h0010), rq(1'b1, ADR_MASK));
		chk(16'(io_n), 16'h0000);
		chk(16'(ds_n), 16'h0001);
		chk(16'(ws.target), 16'(MSD_T_NONE));
		chk(msk, 16'h1234);
		io_space_i = 1'b0;
		rst(1'b1, 1'b0);
		chk(fcnt, 16'h0001);
		conclude();
	end
endmodule
